// >>> design/operand_address_modes.sv
// operand address generator for a pipelined 8-bit core
// assumes a decoder supplies mode and fields, and register values are current
`timescale 1ns/100ps
`include "opaddr_cfg.svh"

// What this block does
// RULE1: direct mode takes an 8-bit field, reaching only internal RAM or special registers.
// RULE2: 8-bit indirect takes its address from bank register 0 or 1.
// RULE3: 16-bit indirect uses the whole data pointer as address.
// RULE4: register mode names one of eight bank registers, no address field.
// RULE5: implied-register instructions act on the accumulator, no operand decoding.
// RULE6: immediate mode passes the instruction byte as data, not address.
// RULE7: indexed mode reads program memory at data pointer plus accumulator.
// RULE8: bit mode picks one bit of a 256-bit space.
// RULE9: low external reset resets the block; pin pulled high when undriven.
// RULE10: bit space is 128 RAM bits plus bit-addressable special registers.
// RULE11: external RAM moves only to or from accumulator, indirect only.
// RULE12: direct addresses from 0x80 up select special registers, lower ones RAM.
module operand_address_modes (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // decoded instruction and register values
    input wire logic req_valid_in,
    input wire opaddr_pkg::op_req_t req_in,
    input wire logic xdata_in,
    // answer to execution unit and memories
    output logic ans_valid_out,
    output opaddr_pkg::op_ans_t ans_out,
    output logic illegal_out
);
    logic rst_sync_b;
    opaddr_pkg::op_ans_t sel_ans;
    opaddr_pkg::op_ans_t ans;
    logic ans_valid;
    logic illegal;

    // release is retimed so no flop sees reset end mid-edge
    reset_sync #(
        .STAGES(`RESET_SYNC_STAGES)
    ) u_reset_sync (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .rst_sync_b_out(rst_sync_b)
    );

    // request fields under their own names
    wire opaddr_pkg::addr_mode_t mode = req_in.mode;
    wire logic [7:0] field = req_in.field;
    wire logic [2:0] reg_idx = req_in.reg_sel[`REG_SEL_MSB:`REG_SEL_LSB];
    wire logic [1:0] bank = req_in.bank;
    wire logic [7:0] acc = req_in.acc;
    wire logic [15:0] data_pointer_register = req_in.data_pointer_register;
    wire logic [7:0] ptr0 = req_in.ptr0;
    wire logic [7:0] ptr1 = req_in.ptr1;

    wire logic is_ind8 = (mode == opaddr_pkg::MODE_IND8);
    wire logic is_ind16 = (mode == opaddr_pkg::MODE_IND16);
    wire logic mode_legal = $onehot(mode);

    // direct: upper half of the byte map is special registers
    wire logic direct_is_special = (field >= `SPECIAL_FUNCTION_REGISTER_BASE); // RULE12
    wire opaddr_pkg::space_t direct_space = direct_is_special ? opaddr_pkg::SPACE_SPECIAL_FUNCTION_REGISTER
                                                              : opaddr_pkg::SPACE_IRAM; // RULE12
    wire opaddr_pkg::op_ans_t direct_ans = '{
        space: direct_space,
        code_rd: 1'b0,
        use_acc: 1'b0,
        imm_valid: 1'b0,
        imm: 8'h00,
        addr: {8'h00, field}, // RULE1
        bit_valid: 1'b0,
        bit_pos: 3'h0
    };

    wire logic [7:0] ind8_addr = reg_idx[`PTR_SEL_BIT] ? ptr1 : ptr0; // RULE2
    wire opaddr_pkg::space_t ind8_space = xdata_in ? opaddr_pkg::SPACE_XRAM : opaddr_pkg::SPACE_IRAM; // RULE11
    wire opaddr_pkg::op_ans_t ind8_ans = '{
        space: ind8_space,
        code_rd: 1'b0,
        use_acc: xdata_in, // RULE11
        imm_valid: 1'b0,
        imm: 8'h00,
        addr: {8'h00, ind8_addr}, // RULE2
        bit_valid: 1'b0,
        bit_pos: 3'h0
    };

    // wide pointer always means external data, never internal ram
    wire opaddr_pkg::op_ans_t ind16_ans = '{
        space: opaddr_pkg::SPACE_XRAM,
        code_rd: 1'b0,
        use_acc: 1'b1, // RULE11
        imm_valid: 1'b0,
        imm: 8'h00,
        addr: data_pointer_register, // RULE3
        bit_valid: 1'b0,
        bit_pos: 3'h0
    };

    wire logic [7:0] reg_addr = ({6'h00, bank} << `BANK_ADDR_SHIFT) | {5'h00, reg_idx}; // RULE4
    wire opaddr_pkg::op_ans_t reg_ans = '{
        space: opaddr_pkg::SPACE_IRAM,
        code_rd: 1'b0,
        use_acc: 1'b0,
        imm_valid: 1'b0,
        imm: 8'h00,
        addr: {8'h00, reg_addr},
        bit_valid: 1'b0,
        bit_pos: 3'h0
    };

    wire opaddr_pkg::op_ans_t implied_ans = '{
        space: opaddr_pkg::SPACE_NONE,
        code_rd: 1'b0,
        use_acc: 1'b1, // RULE5
        imm_valid: 1'b0,
        imm: 8'h00,
        addr: 16'h0000,
        bit_valid: 1'b0,
        bit_pos: 3'h0
    };

    wire opaddr_pkg::op_ans_t imm_ans = '{
        space: opaddr_pkg::SPACE_NONE,
        code_rd: 1'b0,
        use_acc: 1'b0,
        imm_valid: 1'b1, // RULE6
        imm: field,
        addr: 16'h0000,
        bit_valid: 1'b0,
        bit_pos: 3'h0
    };

    // sum wraps at 16 bits; a table may not cross the top of code
    wire logic [15:0] indexed_addr = data_pointer_register + {8'h00, acc}; // RULE7
    wire opaddr_pkg::op_ans_t indexed_ans = '{
        space: opaddr_pkg::SPACE_NONE,
        code_rd: 1'b1, // RULE7
        use_acc: 1'b0,
        imm_valid: 1'b0,
        imm: 8'h00,
        addr: indexed_addr,
        bit_valid: 1'b0,
        bit_pos: 3'h0
    };

    // low half: ram bytes from 0x20, high half: every eighth special register
    wire logic bit_in_special = field[`BIT_AREA_SEL]; // RULE10
    wire logic [7:0] bit_ram_byte = `BIT_RAM_BYTE_BASE + {4'h0, field[`BIT_BYTE_MSB:`BIT_BYTE_LSB]}; // RULE10
    wire logic [7:0] bit_special_byte = field & `BIT_SPECIAL_BYTE_MASK; // RULE10
    wire logic [7:0] bit_byte = bit_in_special ? bit_special_byte : bit_ram_byte; // RULE8
    wire opaddr_pkg::space_t bit_space = bit_in_special ? opaddr_pkg::SPACE_SPECIAL_FUNCTION_REGISTER
                                                        : opaddr_pkg::SPACE_IRAM; // RULE10
    wire opaddr_pkg::op_ans_t bit_ans = '{
        space: bit_space,
        code_rd: 1'b0,
        use_acc: 1'b0,
        imm_valid: 1'b0,
        imm: 8'h00,
        addr: {8'h00, bit_byte},
        bit_valid: 1'b1, // RULE8
        bit_pos: field[`BIT_POS_MSB:0]
    };

    // external data only through indirect pointers, with the accumulator
    wire logic xdata_ok = is_ind8 || is_ind16; // RULE11
    wire logic xdata_bad = xdata_in && !xdata_ok;
    wire logic refuse = !mode_legal || xdata_bad;
    // a refused request touches no memory
    wire opaddr_pkg::op_ans_t refused_ans = '{
        space: opaddr_pkg::SPACE_NONE,
        code_rd: 1'b0,
        use_acc: 1'b0,
        imm_valid: 1'b0,
        imm: 8'h00,
        addr: 16'h0000,
        bit_valid: 1'b0,
        bit_pos: 3'h0
    };

    always_comb begin
        sel_ans = refused_ans;
        unique case (mode)
            opaddr_pkg::MODE_DIRECT: begin
                sel_ans = direct_ans; // RULE1
            end
            opaddr_pkg::MODE_IND8: begin
                sel_ans = ind8_ans; // RULE2
            end
            opaddr_pkg::MODE_IND16: begin
                sel_ans = ind16_ans; // RULE3
            end
            opaddr_pkg::MODE_REG: begin
                sel_ans = reg_ans; // RULE4
            end
            opaddr_pkg::MODE_IMPLIED: begin
                sel_ans = implied_ans; // RULE5
            end
            opaddr_pkg::MODE_IMM: begin
                sel_ans = imm_ans; // RULE6
            end
            opaddr_pkg::MODE_INDEXED: begin
                sel_ans = indexed_ans; // RULE7
            end
            opaddr_pkg::MODE_BIT: begin
                sel_ans = bit_ans; // RULE8
            end
            default: begin
                sel_ans = refused_ans;
            end
        endcase
        if (xdata_bad) begin
            sel_ans = refused_ans; // RULE11
        end
    end

    // answer holds between requests so memories see a steady address
    wire opaddr_pkg::op_ans_t next_ans = req_valid_in ? sel_ans : ans;

    // one register stage, matching the core pipeline
    always_ff @(posedge clk_sys_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ans <= '0; // RULE9
            ans_valid <= 1'b0;
            illegal <= 1'b0;
        end else begin
            ans <= next_ans;
            ans_valid <= req_valid_in && !refuse;
            illegal <= req_valid_in && refuse;
        end
    end

    assign ans_out = ans;
    assign ans_valid_out = ans_valid;
    assign illegal_out = illegal;
endmodule : operand_address_modes

// >>> design/opaddr_cfg.svh
// constants for the operand address generator: field positions, space bounds
// assumes nothing; definitions only
`ifndef OPADDR_CFG_SVH
`define OPADDR_CFG_SVH
`define SPECIAL_FUNCTION_REGISTER_BASE 8'h80
`define BIT_RAM_BYTE_BASE 8'h20
`define BIT_SPECIAL_BYTE_MASK 8'hF8
`define BIT_AREA_SEL 7
`define BIT_BYTE_MSB 6
`define BIT_BYTE_LSB 3
`define BIT_POS_MSB 2
`define REG_SEL_LSB 0
`define REG_SEL_MSB 2
`define PTR_SEL_BIT 0
`define BANK_ADDR_SHIFT 3
`define RESET_SYNC_STAGES 2
`endif

// >>> design/opaddr_pkg.sv
// types shared by the operand address generator files
// assumes opaddr_cfg.svh for numeric constants
package opaddr_pkg;
    typedef enum logic [7:0] {
        MODE_DIRECT = 8'h01,
        MODE_IND8 = 8'h02,
        MODE_IND16 = 8'h04,
        MODE_REG = 8'h08,
        MODE_IMPLIED = 8'h10,
        MODE_IMM = 8'h20,
        MODE_INDEXED = 8'h40,
        MODE_BIT = 8'h80
    } addr_mode_t;

    typedef enum logic [3:0] {
        SPACE_NONE = 4'h1,
        SPACE_IRAM = 4'h2,
        SPACE_SPECIAL_FUNCTION_REGISTER = 4'h4,
        SPACE_XRAM = 4'h8
    } space_t;

    typedef enum logic [2:0] {
        SPACE_CODE_NO = 3'h1,
        SPACE_CODE_RD = 3'h2,
        SPACE_ACC = 3'h4
    } aux_t;

    typedef struct packed {
        addr_mode_t mode;
        logic [7:0] field;
        logic [2:0] reg_sel;
        logic [1:0] bank;
        logic [7:0] acc;
        logic [15:0] data_pointer_register;
        logic [7:0] ptr0;
        logic [7:0] ptr1;
    } op_req_t;

    typedef struct packed {
        space_t space;
        logic code_rd;
        logic use_acc;
        logic imm_valid;
        logic [7:0] imm;
        logic [15:0] addr;
        logic bit_valid;
        logic [2:0] bit_pos;
    } op_ans_t;
endpackage : opaddr_pkg

// >>> design/reset_sync.sv
// reset conditioner for the external reset input
// assumes the pad keeps the pin high through its pull-up when undriven
`timescale 1ns/100ps
module reset_sync #(
    parameter int STAGES = 2
) (
    // clock and raw reset
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // conditioned reset
    output logic rst_sync_b_out
);
    logic [STAGES-1:0] chain;

    // async assert, synchronous release
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            chain <= '0; // RULE9
        end else begin
            chain <= {chain[STAGES-2:0], 1'b1};
        end
    end

    assign rst_sync_b_out = chain[STAGES-1];
endmodule : reset_sync

// >>> verification/opaddr_props.sv
// port assertions for the operand address generator
// assumes binding onto operand_address_modes
`timescale 1ns/100ps
module opaddr_props (
    // watched ports
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic req_valid_in,
    input wire opaddr_pkg::op_req_t req_in,
    input wire logic xdata_in,
    input wire logic ans_valid_out,
    input wire opaddr_pkg::op_ans_t ans_out,
    input wire logic illegal_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    // one-hot mode bits, so m[k] names one mode
    wire [7:0] m = req_in.mode;
    wire v = req_valid_in && !xdata_in && $onehot(m);
    direct_addr_a: assert property (v && m[0] |=> ans_valid_out &&
        ans_out.addr == $past(req_in.field) && ans_out.space[2] == $past(req_in.field[7])) else $error("direct");
    ptr_low_a: assert property (v && m[1] |=>
        ans_out.addr == ($past(req_in.reg_sel[0]) ? $past(req_in.ptr1) : $past(req_in.ptr0))) else $error("ind8");
    ptr_wide_a: assert property (req_valid_in && m == 8'h04 |=> ans_out.addr == $past(req_in.data_pointer_register))
        else $error("ind16");
    bank_reg_a: assert property (v && m[3] |=>
        ans_out.addr == {11'h000, $past(req_in.bank), $past(req_in.reg_sel)}) else $error("reg");
    implied_acc_a: assert property (v && m[4] |=> ans_out.use_acc && ans_out.space == 4'h1)
        else $error("implied");
    imm_data_a: assert property (v && m[5] |=> ans_out.imm_valid && ans_out.imm == $past(req_in.field))
        else $error("imm");
    code_index_a: assert property (v && m[6] |=>
        ans_out.code_rd && ans_out.addr == $past(req_in.data_pointer_register) + $past(req_in.acc))
        else $error("indexed");
    bit_pick_a: assert property (v && m[7] |=> ans_out.bit_valid &&
        ans_out.bit_pos == $past(req_in.field[2:0])) else $error("bit");
    xram_only_a: assert property (req_valid_in && xdata_in && !m[1] && !m[2] |=> illegal_out)
        else $error("xdata");
    cover property (illegal_out);
    cover property (v && m[7]);
    cover property (ans_valid_out ##1 ans_valid_out);
endmodule : opaddr_props
bind operand_address_modes opaddr_props i_props (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .req_valid_in(req_valid_in),
    .req_in(req_in),
    .xdata_in(xdata_in),
    .ans_valid_out(ans_valid_out),
    .ans_out(ans_out),
    .illegal_out(illegal_out)
);

// >>> verification/opaddr_mem.sv
// memories behind the answer: ram, special registers, code
// assumes ans_in steady while ans_valid_in is high
`timescale 1ns/100ps
module opaddr_mem (
    // clock and answer
    input wire logic clk_sys_in,
    input wire logic ans_valid_in,
    input wire opaddr_pkg::op_ans_t ans_in,
    // read data
    output logic [7:0] rd_data_out
);
    logic [7:0] last = 8'h00;
    // idle shows inverse of last byte, never a stale match
    assign rd_data_out = !ans_valid_in ? ~last : ans_in.code_rd ? ~ans_in.addr[7:0] : ans_in.addr[7:0];
    always_ff @(posedge clk_sys_in) if (ans_valid_in) last <= rd_data_out;
endmodule : opaddr_mem

// >>> verification/operand_address_modes_bench.sv
// bench for the operand address generator
// assumes design files and opaddr_mem compiled first
`timescale 1ns/100ps
module operand_address_modes_bench;
    logic clk_sys_in = 0, rst_b_in = 0, req_valid_in = 0, xdata_in = 0;
    opaddr_pkg::op_req_t req_in = '0;
    logic ans_valid_out, illegal_out;
    opaddr_pkg::op_ans_t ans_out;
    logic [7:0] rd;
    int n_errors = 0, checks_done = 0;
    always #50 clk_sys_in = ~clk_sys_in;
    operand_address_modes i_dut (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .req_valid_in(req_valid_in),
        .req_in(req_in),
        .xdata_in(xdata_in),
        .ans_valid_out(ans_valid_out),
        .ans_out(ans_out),
        .illegal_out(illegal_out)
    );
    opaddr_mem i_mem (.clk_sys_in(clk_sys_in), .ans_valid_in(ans_valid_out), .ans_in(ans_out), .rd_data_out(rd));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %0t: %h not %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %0t: read %h not %h", $time, got, exp);
        end
    endtask : chk_rd
    // request held from falling edge; answer seen one falling edge later
    task automatic go(input logic [7:0] md, input logic [7:0] f, input logic x);
        req_in.mode = opaddr_pkg::addr_mode_t'(md);
        req_in.field = f;
        xdata_in = x;
        req_valid_in = 1;
        @(negedge clk_sys_in);
    endtask : go
    task automatic t_reset(input int n);
        req_valid_in = 0;
        rst_b_in = 0;
        repeat (n) @(negedge clk_sys_in);
        chk({ans_valid_out, illegal_out, ans_out.space, ans_out.addr}, 24'h0);
        rst_b_in = 1;
        repeat (3) @(negedge clk_sys_in);
    endtask : t_reset
    task automatic t_direct;
        for (int i = 0; i < 4; i++) begin
            go(8'h01, 8'h7E + 8'(i), 0);
            chk({ans_out.space, ans_out.addr}, (i < 2 ? 24'h2007E : 24'h4007E) + 24'(i));
        end
    endtask : t_direct
    task automatic t_ind;
        req_in.ptr0 = 8'h3C;
        req_in.ptr1 = 8'hC3;
        req_in.data_pointer_register = 16'hFFF0;
        go(8'h02, 8'h00, 0);
        chk({ans_out.space, ans_out.addr}, 24'h2003C);
        req_in.reg_sel = 3'h1;
        go(8'h02, 8'h00, 1);
        chk({ans_out.use_acc, ans_out.space, ans_out.addr}, 24'h1800C3);
        go(8'h04, 8'h00, 1);
        chk({ans_out.use_acc, ans_out.space, ans_out.addr}, 24'h18FFF0);
    endtask : t_ind
    task automatic t_misc;
        req_in.bank = 2'h2;
        req_in.reg_sel = 3'h5;
        req_in.acc = 8'h20;
        go(8'h08, 8'h00, 0);
        chk({ans_valid_out, ans_out.space, ans_out.addr}, 24'h120015);
        go(8'h10, 8'h00, 0);
        chk({ans_out.use_acc, ans_out.space}, 24'h11);
        go(8'h20, 8'h5A, 0);
        chk({ans_out.imm_valid, ans_out.imm, ans_out.space}, 24'h15A1);
        go(8'h40, 8'h00, 0);
        chk({ans_out.code_rd, ans_out.addr}, 24'h10010);
        chk_rd(rd, 8'hEF);
    endtask : t_misc
    task automatic t_bit_bad;
        go(8'h80, 8'h7F, 0);
        chk({ans_out.bit_valid, ans_out.bit_pos, ans_out.addr}, 24'hF002F);
        go(8'h80, 8'h87, 0);
        chk({ans_out.space, ans_out.bit_pos, ans_out.addr}, 24'h270080);
        go(8'h01, 8'h10, 1);
        chk({illegal_out, ans_valid_out, ans_out.space}, 24'h21);
        go(8'h03, 8'h00, 0);
        chk({illegal_out, ans_valid_out, ans_out.space, ans_out.addr}, 24'h210000);
        req_valid_in = 0;
    endtask : t_bit_bad
    task automatic print_verdict;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    initial begin
        t_reset(20);
        t_direct;
        t_reset(2);
        t_ind;
        t_misc;
        t_bit_bad;
        print_verdict;
    end
    // about 43 cycles of tests; 300 cycles means a hang
    initial begin
        #30000;
        n_errors++;
        print_verdict;
    end
endmodule : operand_address_modes_bench
